// ===== include/spi_ctl_pkg.sv
// shared constants and carrier types for the serial control and status block
package spi_ctl_pkg;
  localparam int          DATA_W       = 8;
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [1:0]  SEL_MODE_RST = 2'h1;
  localparam logic [1:0]  SEL_3WIRE    = 2'h0;
  localparam logic [1:0]  SEL_4W_IN    = 2'h1;
  localparam int          SEL_HI_BIT   = 1;
  localparam int          SEL_LO_BIT   = 0;
  localparam logic [7:0]  CLK_DIV_RST  = 8'h00;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  SYNC_RST     = 3'h7;

  typedef struct packed {
    logic [1:0] sel_mode_field;
    logic       master_enable_bit;
    logic       unit_enable_bit;
  } ctrl_t;

  typedef struct packed {
    logic rx_overrun_flag;
    logic tx_buffer_empty;
    logic transfer_done_flag;
    logic mode_fault_flag;
  } stat_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } xfer_state_t;
endpackage

// ===== core/spi_ctl_fifo.sv
// parameterised valid/ready fifo for received bytes
`timescale 1ns/1ps
module spi_ctl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];

  always_ff @(posedge clk)
    if (push)
      mem[wr_ptr_ff] <= in_data;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
endmodule // spi_ctl_fifo

// ===== core/spi_ctl_top.sv
// serial unit core: overrun, select mode, tx empty, enable, done and fault flags
// Behaviour
// - A slave transfer whose last bit arrives while the receive fifo is full sets overrun.
// - Overrun is set only in slave operation, never as master.
// - Overrun stays set until software clears it; hardware never clears it.
// - Select mode 00 is three-wire and leaves the select pin undriven and unused.
// - Select mode 01, the reset default, uses the select pin only as an input.
// - Select mode 1x, with the unit enabled, drives the select pin with the field's low bit.
// - Writing a byte to the transmit buffer while the unit is enabled clears the empty flag, unless a shift-register load sets it in the same cycle.
// - Moving the buffered byte into the shift register sets the empty flag.
// - The done flag is set at the end of each transfer.
// - Select low while master is enabled in mode 01 sets the mode fault flag.
`timescale 1ns/1ps
module spi_ctl_top #(
  parameter int DATA_W = spi_ctl_pkg::DATA_W,
  parameter int DEPTH  = spi_ctl_pkg::FIFO_DEPTH
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RESET_N,
  input  wire logic              UNIT_ENABLE,
  input  wire logic              MASTER_ENABLE,
  input  wire logic [1:0]        SEL_MODE,
  input  wire logic [7:0]        CLK_DIV,
  input  wire logic              TX_WRITE,
  input  wire logic [DATA_W-1:0] TX_DATA,
  input  wire logic              RX_READ,
  output      logic [DATA_W-1:0] RX_DATA,
  output      logic              RX_VALID,
  input  wire logic              CLR_OVERRUN,
  input  wire logic              CLR_DONE,
  input  wire logic              CLR_FAULT,
  output      logic              RX_OVERRUN,
  output      logic              TX_EMPTY,
  output      logic              XFER_DONE,
  output      logic              MODE_FAULT,
  input  wire logic              SEL_IN,
  output      logic              SEL_OUT,
  output      logic              SEL_OE_N,
  input  wire logic              SCK_IN,
  output      logic              SCK_OUT,
  input  wire logic              SDI,
  output      logic              SDO
);
  spi_ctl_pkg::ctrl_t       ctrl;
  spi_ctl_pkg::stat_t       stat_ff;
  spi_ctl_pkg::stat_t       nxt_stat;
  spi_ctl_pkg::xfer_state_t state_ff;
  spi_ctl_pkg::xfer_state_t nxt_state;
  logic [2:0]        sel_sync_ff;
  logic [2:0]        sck_sync_ff;
  logic [2:0]        sdi_sync_ff;
  logic              sel_q_ff;
  logic              sck_q_ff;
  logic              sck_prev_ff;
  logic              sdi_q_ff;
  logic [DATA_W-1:0] tx_buf_ff;
  logic [DATA_W-1:0] shift_ff;
  logic [2:0]        bit_cnt_ff;
  logic [7:0]        div_cnt_ff;
  logic              sck_gen_ff;
  logic              sel_out_ff;
  logic              sel_oe_n_ff;
  logic              sdo_ff;
  logic              rx_data_valid;
  logic              fifo_in_ready;

  // 2nd and 3rd stages agree before a pin change counts
  function automatic logic settle(input logic [2:0] s, input logic old);
    return (s[1] == s[2]) ? s[2] : old;
  endfunction

  assign ctrl = '{sel_mode_field: SEL_MODE, master_enable_bit: MASTER_ENABLE,
                  unit_enable_bit: UNIT_ENABLE};
  wire is_master   = ctrl.unit_enable_bit && ctrl.master_enable_bit;
  wire is_slave    = ctrl.unit_enable_bit && !ctrl.master_enable_bit;
  wire sel_in_used = (ctrl.sel_mode_field == spi_ctl_pkg::SEL_4W_IN);
  wire sel_drive   = ctrl.sel_mode_field[spi_ctl_pkg::SEL_HI_BIT];
  // slave outside select mode 01 is always selected; mode 01 slave needs select low
  wire selected    = is_slave && (!sel_in_used || !sel_q_ff);
  wire sck_rise    = selected && sck_q_ff && !sck_prev_ff;
  wire mst_tick    = is_master && (div_cnt_ff == CLK_DIV);
  wire shift_tick  = (state_ff == spi_ctl_pkg::ST_SHIFT) &&
                     (is_master ? (mst_tick && sck_gen_ff) : sck_rise);
  wire last_bit    = shift_tick && (bit_cnt_ff == spi_ctl_pkg::BIT_LAST);
  wire load_shift  = (state_ff == spi_ctl_pkg::ST_IDLE) && !stat_ff.tx_buffer_empty &&
                     (is_master || selected);
  wire overrun_ev  = last_bit && is_slave && !fifo_in_ready;
  wire fault_ev    = is_master && sel_in_used && !sel_q_ff;
  wire tx_accept   = TX_WRITE && ctrl.unit_enable_bit;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      spi_ctl_pkg::ST_IDLE:  if (load_shift) nxt_state = spi_ctl_pkg::ST_SHIFT;
      spi_ctl_pkg::ST_SHIFT: if (last_bit) nxt_state = spi_ctl_pkg::ST_DONE;
      spi_ctl_pkg::ST_DONE:  nxt_state = spi_ctl_pkg::ST_IDLE;
      default:               nxt_state = spi_ctl_pkg::ST_IDLE;
    endcase
    if (!ctrl.unit_enable_bit)
      nxt_state = spi_ctl_pkg::ST_IDLE;
  end

  // set beats clear on every sticky flag
  always_comb
  begin
    nxt_stat = stat_ff;
    if (CLR_OVERRUN) nxt_stat.rx_overrun_flag = 1'b0;
    if (overrun_ev)  nxt_stat.rx_overrun_flag = 1'b1;
    if (tx_accept)   nxt_stat.tx_buffer_empty = 1'b0;
    if (load_shift)  nxt_stat.tx_buffer_empty = 1'b1;
    if (CLR_DONE)    nxt_stat.transfer_done_flag = 1'b0;
    if (last_bit)    nxt_stat.transfer_done_flag = 1'b1;
    if (CLR_FAULT)   nxt_stat.mode_fault_flag = 1'b0;
    if (fault_ev)    nxt_stat.mode_fault_flag = 1'b1;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      sel_sync_ff <= spi_ctl_pkg::SYNC_RST;
      sck_sync_ff <= '0;
      sdi_sync_ff <= '0;
      sel_q_ff    <= 1'b1;
      sck_q_ff    <= 1'b0;
      sck_prev_ff <= 1'b0;
      sdi_q_ff    <= 1'b0;
    end
    else
    begin
      sel_sync_ff <= {sel_sync_ff[1:0], SEL_IN};
      sck_sync_ff <= {sck_sync_ff[1:0], SCK_IN};
      sdi_sync_ff <= {sdi_sync_ff[1:0], SDI};
      sel_q_ff    <= settle(sel_sync_ff, sel_q_ff);
      sck_q_ff    <= settle(sck_sync_ff, sck_q_ff);
      sck_prev_ff <= sck_q_ff;
      sdi_q_ff    <= settle(sdi_sync_ff, sdi_q_ff);
    end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      state_ff   <= spi_ctl_pkg::ST_IDLE;
      stat_ff    <= '{1'b0, 1'b1, 1'b0, 1'b0};
      tx_buf_ff  <= '0;
      shift_ff   <= '0;
      bit_cnt_ff <= '0;
      div_cnt_ff <= spi_ctl_pkg::CLK_DIV_RST;
      sck_gen_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      stat_ff  <= nxt_stat;
      if (tx_accept)
        tx_buf_ff <= TX_DATA;
      if (load_shift)
        shift_ff <= tx_buf_ff;
      else if (shift_tick)
        shift_ff <= {shift_ff[DATA_W-2:0], sdi_q_ff};
      if (load_shift)
        bit_cnt_ff <= '0;
      else if (shift_tick)
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      // master clock period is 2*(div+1) core cycles
      if (!is_master || state_ff != spi_ctl_pkg::ST_SHIFT)
      begin
        div_cnt_ff <= spi_ctl_pkg::CLK_DIV_RST;
        sck_gen_ff <= 1'b0;
      end
      else if (mst_tick)
      begin
        div_cnt_ff <= spi_ctl_pkg::CLK_DIV_RST;
        sck_gen_ff <= !sck_gen_ff;
      end
      else
        div_cnt_ff <= div_cnt_ff + 8'h01;
    end

  // pin drivers registered so outputs come straight from flops
  always_ff @(posedge CORE_CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      sel_out_ff  <= 1'b1;
      sel_oe_n_ff <= 1'b1;
      sdo_ff      <= 1'b0;
    end
    else
    begin
      sel_out_ff  <= ctrl.sel_mode_field[spi_ctl_pkg::SEL_LO_BIT];
      sel_oe_n_ff <= !(ctrl.unit_enable_bit && sel_drive);
      sdo_ff      <= shift_ff[DATA_W-1];
    end

  assign SCK_OUT    = sck_gen_ff;
  assign SEL_OUT    = sel_out_ff;
  assign SEL_OE_N   = sel_oe_n_ff;
  assign SDO        = sdo_ff;
  assign RX_OVERRUN = stat_ff.rx_overrun_flag;
  assign TX_EMPTY   = stat_ff.tx_buffer_empty;
  assign XFER_DONE  = stat_ff.transfer_done_flag;
  assign MODE_FAULT = stat_ff.mode_fault_flag;

  // a full receive buffer drops the new byte; overrun reports that loss in slave operation only
  spi_ctl_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk       (CORE_CLK),
    .rst_n     (RESET_N),
    .in_valid  (last_bit),
    .in_ready  (fifo_in_ready),
    .in_data   ({shift_ff[DATA_W-2:0], sdi_q_ff}),
    .out_valid (rx_data_valid),
    .out_ready (RX_READ),
    .out_data  (RX_DATA)
  );
  assign RX_VALID = rx_data_valid;

  a_overrun_sticky: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (RX_OVERRUN && !CLR_OVERRUN) |=> RX_OVERRUN) else $error("overrun lost");
  a_overrun_cause: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(RX_OVERRUN) |-> !$past(fifo_in_ready) && $past(is_slave)) else $error("bad overrun");
  a_overrun_master: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (UNIT_ENABLE && MASTER_ENABLE) |=> !$rose(RX_OVERRUN)) else $error("overrun as master");
  a_sel_mode_in: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (SEL_MODE == spi_ctl_pkg::SEL_3WIRE) |=> SEL_OE_N) else $error("select driven");
  a_sel_mode_out: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (sel_drive && UNIT_ENABLE) |=> !SEL_OE_N && SEL_OUT == $past(SEL_MODE[0]))
    else $error("select not driven");
  a_sel_default: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (SEL_MODE == spi_ctl_pkg::SEL_4W_IN) |=> SEL_OE_N) else $error("mode 01 drives select");
  a_tx_write_clr: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (tx_accept && !load_shift) |=> !TX_EMPTY) else $error("empty not cleared");
  a_tx_load_set: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    load_shift |=> TX_EMPTY && state_ff == spi_ctl_pkg::ST_SHIFT) else $error("load failed");
  a_enable_gate: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    !UNIT_ENABLE |=> state_ff == spi_ctl_pkg::ST_IDLE) else $error("runs disabled");
  a_done_set: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    last_bit |=> XFER_DONE ##1 state_ff == spi_ctl_pkg::ST_IDLE) else $error("no done");
  a_fault_set: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    fault_ev |=> MODE_FAULT) else $error("no mode fault");
endmodule // spi_ctl_top

// ===== dv/spi_peer_model.sv
// external serial master standing at the unit's pins
`timescale 1ns/1ps
module spi_peer_model #(
  parameter int HALF = 4
) (
  input  wire logic clk,
  output      logic sck,
  output      logic sdi,
  output      logic sel_n
);
  logic busy;
  initial
  begin
    busy = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
    sel_n = 1'b1;
  end
  // released data line toggles so a stale value can never pass
  always @(posedge clk)
    if (!busy)
      sdi <= ~sdi;
  task automatic set_sel(input logic v);
    @(posedge clk);
    sel_n <= v;
  endtask
  // eight bits msb first, clock idle low outside the frame
  task automatic send_byte(input logic [7:0] d);
    // busy set ahead of the edge so the idle toggle cannot race the first bit
    busy = 1'b1;
    @(posedge clk);
    sel_n <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      sdi <= d[i];
      repeat (HALF) @(posedge clk);
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    sel_n <= 1'b1;
    busy <= 1'b0;
  endtask
endmodule // spi_peer_model

// ===== dv/spi_ctrl_status_bits_tb.sv
// self-checking bench for the serial control and status bits
`timescale 1ns/1ps
module spi_ctrl_status_bits_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       en = 1'b0;
  logic       mst = 1'b0;
  logic [1:0] mode = spi_ctl_pkg::SEL_MODE_RST;
  logic       wr = 1'b0;
  logic [7:0] wdat = 8'h00;
  logic       rd = 1'b0;
  logic       clr_ovr = 1'b0;
  logic       clr_done = 1'b0;
  logic       clr_flt = 1'b0;
  logic [7:0] rdat;
  logic       rvalid, ovr, empty, done, flt, sel_out, sel_oe_n, sck_out, sdo, sck, sdi, sel_n;
  int         n_mismatch = 0;
  int         comparisons = 0;
  logic [7:0] sdo_cap = 8'h00;

  spi_ctl_top dut (.CORE_CLK(clk), .RESET_N(rst_n), .UNIT_ENABLE(en), .MASTER_ENABLE(mst),
    .SEL_MODE(mode), .CLK_DIV(8'h00), .TX_WRITE(wr), .TX_DATA(wdat), .RX_READ(rd),
    .RX_DATA(rdat), .RX_VALID(rvalid), .CLR_OVERRUN(clr_ovr), .CLR_DONE(clr_done),
    .CLR_FAULT(clr_flt), .RX_OVERRUN(ovr), .TX_EMPTY(empty), .XFER_DONE(done),
    .MODE_FAULT(flt), .SEL_IN(sel_n), .SEL_OUT(sel_out), .SEL_OE_N(sel_oe_n),
    .SCK_IN(sck), .SCK_OUT(sck_out), .SDI(sdi), .SDO(sdo));
  spi_peer_model peer (.clk(clk), .sck(sck), .sdi(sdi), .sel_n(sel_n));

  always #50 clk = ~clk;

  // serial out sampled mid-cycle while the master clock is high
  always @(negedge clk)
    if (sck_out)
      sdo_cap <= {sdo_cap[6:0], sdo};

  task automatic chk1(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // order of bits: overrun, done, fault
  task automatic pulse_clr(input logic [2:0] which);
    @(posedge clk);
    {clr_ovr, clr_done, clr_flt} <= which;
    @(posedge clk);
    {clr_ovr, clr_done, clr_flt} <= 3'h0;
  endtask
  task automatic write_byte(input logic [7:0] d);
    @(posedge clk);
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic master_xfer(input logic [7:0] d);
    write_byte(d);
    @(negedge clk);
    chk1(empty, 1'b0, "tx empty after write");
    @(negedge clk);
    chk1(empty, 1'b1, "tx empty after load");
    for (int i = 0; i < 100 && done !== 1'b1; i++)
      @(negedge clk);
    chk1(done, 1'b1, "transfer done");
    chk1(ovr, 1'b0, "overrun as master");
    chk8(sdo_cap, d, "serial out");
    chk1(sck_out, 1'b0, "clock idle after frame");
    pulse_clr(3'h2);
    @(negedge clk);
    chk1(done, 1'b0, "done cleared");
  endtask
  task automatic pop(input logic [7:0] exp, input bit cmp);
    @(negedge clk);
    chk1(rvalid, 1'b1, "rx valid");
    if (cmp)
      chk8(rdat, exp, "rx data");
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk1(empty, 1'b1, "tx empty at reset");
    chk1(ovr, 1'b0, "overrun at reset");
    chk1(sel_oe_n, 1'b1, "select drive at reset");
    write_byte(8'h3C);
    repeat (2) @(negedge clk);
    chk1(empty, 1'b1, "write while disabled");
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk);
      en <= 1'b1;
      mode <= 2'(m);
      repeat (3) @(negedge clk);
      chk1(sel_oe_n, ~mode[1], "select drive");
      if (mode[1])
        chk1(sel_out, mode[0], "select level");
    end
    @(posedge clk);
    en <= 1'b0;
    repeat (3) @(negedge clk);
    chk1(sel_oe_n, 1'b1, "select drive disabled");
    @(posedge clk);
    en <= 1'b1;
    mst <= 1'b1;
    // one byte past a full fifo: master must still never flag overrun
    for (int k = 0; k < 33; k++)
      master_xfer(8'(k));
    chk1(flt, 1'b0, "no fault in mode 11");
    for (int k = 0; k < 32; k++)
      pop(8'h00, 1'b0);
    @(posedge clk);
    mode <= spi_ctl_pkg::SEL_4W_IN;
    peer.set_sel(1'b0);
    for (int i = 0; i < 10 && flt !== 1'b1; i++)
      @(negedge clk);
    chk1(flt, 1'b1, "mode fault");
    peer.set_sel(1'b1);
    // synced select lags; set beats clear
    repeat (6) @(posedge clk);
    pulse_clr(3'h1);
    @(negedge clk);
    chk1(flt, 1'b0, "fault cleared");
    @(posedge clk);
    mst <= 1'b0;
    // a slave frame starts from a loaded byte; let select settle high first
    for (int k = 0; k < 33; k++)
    begin
      repeat (5) @(negedge clk);
      chk1(ovr, 1'b0, "overrun before full");
      write_byte(8'h00);
      peer.send_byte(8'(k * 7) ^ 8'hA5);
    end
    for (int i = 0; i < 10 && ovr !== 1'b1; i++)
      @(negedge clk);
    chk1(ovr, 1'b1, "overrun on full");
    for (int k = 0; k < 32; k++)
      pop(8'(k * 7) ^ 8'hA5, 1'b1);
    @(negedge clk);
    chk1(rvalid, 1'b0, "fifo drained");
    chk1(ovr, 1'b1, "overrun held");
    pulse_clr(3'h4);
    @(negedge clk);
    chk1(ovr, 1'b0, "overrun cleared");
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule // spi_ctrl_status_bits_tb
